//--- tsf_pkg.sv
// tsf_pkg: shared constants for the channel 4/5 timer status flag block
// assumes a 32-bit AHB-Lite register bus, one word per register
`default_nettype none
package tsf_pkg;
    // register byte offsets
    localparam logic [7:0] STATUS_OFFSET = 8'h00;
    localparam logic [7:0] MASK_OFFSET   = 8'h04;
    localparam logic [7:0] CTRL_OFFSET   = 8'h08;
    // flag bit positions in the status word
    localparam int FLAG_C4A  = 5;
    localparam int FLAG_C4B  = 6;
    localparam int FLAG_C4C  = 7;
    localparam int FLAG_C4D  = 8;
    localparam int FLAG_WRAP = 9;
    localparam int FLAG_C5A  = 10;
    localparam int FLAG_C5B  = 11;
    localparam int FLAG_C5C  = 12;
    localparam logic [15:0] FLAG_MASK   = 16'h1FE0;
    localparam logic [15:0] FLAG_RESET  = 16'h0000;
    localparam logic [15:0] CNT_MAX     = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO    = 16'h0000;
    // control word fields: bit0 ch4 pwm, bit1 ch5 pwm, capture-mode select bits
    localparam int CTRL_PWM4   = 0;
    localparam int CTRL_PWM5   = 1;
    localparam int CTRL_CAP4A  = 4;
    localparam int CTRL_CAP4B  = 5;
    localparam int CTRL_CAP4C  = 6;
    localparam int CTRL_CAP4D  = 7;
    localparam int CTRL_CAP5A  = 8;
    localparam int CTRL_CAP5B  = 9;
    localparam int CTRL_CAP5C  = 10;
    localparam logic [15:0] CTRL_WMASK = 16'h07F3;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : tsf_pkg
`default_nettype wire

//--- tsf_status_flags.sv
// tsf_status_flags: status flags for timer channels 4 and 5 behind AHB-Lite
// assumes counters, general registers and capture strobes come from sibling logic,
// all synchronous to clk
`default_nettype none
module tsf_status_flags
    import tsf_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // channel 4 timer side
    input  wire logic [15:0] ch4Counter,
    input  wire logic [15:0] ch4GeneralRegA,
    input  wire logic [15:0] ch4GeneralRegB,
    input  wire logic [15:0] ch4GeneralRegC,
    input  wire logic [15:0] ch4GeneralRegD,
    input  wire logic [3:0]  ch4CaptureStrobe,
    // channel 5 timer side
    input  wire logic [15:0] ch5Counter,
    input  wire logic [15:0] ch5GeneralRegA,
    input  wire logic [15:0] ch5GeneralRegB,
    input  wire logic [15:0] ch5GeneralRegC,
    input  wire logic [2:0]  ch5CaptureStrobe,
    // mode outputs for the channels and interrupt
    output logic             ch4PwmMode,
    output logic             ch5PwmMode,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [15:0] flags_q, flags_d;
    logic [15:0] armed_q, armed_d;     // flags seen as one by a status read
    logic [15:0] mask_q, mask_d;
    logic [15:0] ctrl_q, ctrl_d;
    logic [15:0] prevCnt4_q;
    logic        wrValid_q, rdValid_q;
    logic [7:0]  addr_q;
    logic [31:0] hrdata_q;
    logic        irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode: the slave is always ready, so every data phase is one cycle
    wire        accept     = hsel & hready & (htrans == HTRANS_NONSEQ);
    wire        wrStatus   = wrValid_q & (addr_q == STATUS_OFFSET);
    wire        wrMask     = wrValid_q & (addr_q == MASK_OFFSET);
    wire        wrCtrl     = wrValid_q & (addr_q == CTRL_OFFSET);
    wire        rdStatus   = accept & ~hwrite & (haddr == STATUS_OFFSET);
    wire [15:0] wdataLow   = hwdata[15:0];

    ////////////////////////////////////////////////////////////////////////////
    // event detection
    wire pwm4 = ctrl_q[CTRL_PWM4];
    wire pwm5 = ctrl_q[CTRL_PWM5];

    // capture mode takes strobe, compare mode takes counter equality
    function automatic logic hit(input logic capMode, input logic strobe,
                                 input logic [15:0] cnt, input logic [15:0] gr);
        hit = capMode ? strobe : (cnt == gr);
    endfunction

    wire ev4a = ~pwm4 & hit(ctrl_q[CTRL_CAP4A], ch4CaptureStrobe[0], ch4Counter, ch4GeneralRegA);
    wire ev4b = ~pwm4 & hit(ctrl_q[CTRL_CAP4B], ch4CaptureStrobe[1], ch4Counter, ch4GeneralRegB);
    wire ev4c = ~pwm4 & hit(ctrl_q[CTRL_CAP4C], ch4CaptureStrobe[2], ch4Counter, ch4GeneralRegC);
    // in PWM, reg D is the synchronous register and compares only
    wire ev4d = pwm4 ? (ch4Counter == ch4GeneralRegD)
                     : hit(ctrl_q[CTRL_CAP4D], ch4CaptureStrobe[3], ch4Counter, ch4GeneralRegD);
    wire ev5a = ~pwm5 & hit(ctrl_q[CTRL_CAP5A], ch5CaptureStrobe[0], ch5Counter, ch5GeneralRegA);
    wire ev5b = ~pwm5 & hit(ctrl_q[CTRL_CAP5B], ch5CaptureStrobe[1], ch5Counter, ch5GeneralRegB);
    // reg C of channel 5 is not blocked by PWM mode
    wire ev5c = hit(ctrl_q[CTRL_CAP5C], ch5CaptureStrobe[2], ch5Counter, ch5GeneralRegC);
    wire wrap4 = (prevCnt4_q == CNT_MAX) & (ch4Counter == CNT_ZERO);

    wire [15:0] setVec;
    assign setVec[4:0]       = 5'h00;
    assign setVec[FLAG_C4A]  = ev4a;
    assign setVec[FLAG_C4B]  = ev4b;
    assign setVec[FLAG_C4C]  = ev4c;
    assign setVec[FLAG_C4D]  = ev4d;
    assign setVec[FLAG_WRAP] = wrap4;
    assign setVec[FLAG_C5A]  = ev5a;
    assign setVec[FLAG_C5B]  = ev5b;
    assign setVec[FLAG_C5C]  = ev5c;
    assign setVec[15:13]     = 3'h0;

    ////////////////////////////////////////////////////////////////////////////
    // clear only armed flags written as zero; ones in the write are ignored
    wire [15:0] clrVec = wrStatus ? (armed_q & ~wdataLow & FLAG_MASK) : 16'h0000;

    always_comb begin
        flags_d = ((flags_q & ~clrVec) | setVec) & FLAG_MASK;
        // arming survives until the next status write of any value; a read captures fresh ones
        armed_d = rdStatus ? flags_q : (wrStatus ? 16'h0000 : armed_q);
        mask_d  = wrMask ? (wdataLow & FLAG_MASK) : mask_q;
        ctrl_d  = wrCtrl ? (wdataLow & CTRL_WMASK) : ctrl_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // flag, mask and control registers
    always_ff @(posedge clk) begin
        if (rst) begin
            flags_q <= FLAG_RESET;
            armed_q <= 16'h0000;
            mask_q  <= 16'h0000;
            ctrl_q  <= 16'h0000;
        end else begin
            flags_q <= flags_d;
            armed_q <= armed_d;
            mask_q  <= mask_d;
            ctrl_q  <= ctrl_d;
        end
    end

    // previous counter value for wrap detection
    always_ff @(posedge clk) begin
        if (rst) begin
            prevCnt4_q <= 16'h0000;
        end else begin
            prevCnt4_q <= ch4Counter;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus address phase capture and read data
    wire [31:0] rdMux = (haddr == STATUS_OFFSET) ? {16'h0000, flags_q} :
                        (haddr == MASK_OFFSET)   ? {16'h0000, mask_q}  :
                        (haddr == CTRL_OFFSET)   ? {16'h0000, ctrl_q}  : 32'h0000_0000;

    always_ff @(posedge clk) begin
        if (rst) begin
            wrValid_q <= 1'b0;
            rdValid_q <= 1'b0;
            addr_q    <= 8'h00;
            hrdata_q  <= 32'h0000_0000;
        end else begin
            wrValid_q <= accept & hwrite;
            rdValid_q <= accept & ~hwrite;
            addr_q    <= accept ? haddr : addr_q;
            hrdata_q  <= (accept & ~hwrite) ? rdMux : 32'h0000_0000;
        end
    end

    // interrupt: any unmasked flag, registered
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(flags_d & mask_q);
        end
    end

    assign hrdata     = hrdata_q;
    assign hreadyout  = 1'b1;     // zero wait states
    assign hresp      = 1'b0;     // always OKAY
    assign ch4PwmMode = ctrl_q[CTRL_PWM4];
    assign ch5PwmMode = ctrl_q[CTRL_PWM5];
    assign irq        = irq_q;

endmodule : tsf_status_flags
`default_nettype wire

//--- tsf_sva.sv
// tsf_sva: port assertions for the channel 4/5 status flag block
// assumes one clock domain and a single word-wide AHB-Lite master
`default_nettype none
module tsf_sva
    import tsf_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [15:0] ch4Counter,
    input wire logic        irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // address phase decode, the same take condition the slave uses
    wire logic take  = hsel && hready && htrans == HTRANS_NONSEQ;
    wire logic rdSts = take && !hwrite && haddr == STATUS_OFFSET;
    ////////////////////////////////////////////////////////////////////////////////
    property p_rst; $fell(rst) |-> !irq && hrdata == 32'h0; endproperty
    a_rst: assert property (p_rst) else $error("outputs not clear after reset");
    property p_ready; hreadyout; endproperty
    a_ready: assert property (p_ready) else $error("wait state inserted");
    property p_okay; !hresp; endproperty
    a_okay: assert property (p_okay) else $error("error response seen");
    property p_upper; hrdata[31:16] == 16'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read half not zero");
    // reserved status bits can never be set by any write
    property p_rsvd; rdSts |=> (hrdata[15:0] & ~FLAG_MASK) == 16'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("status bit outside flags set");
    property p_idle; !(take && !hwrite) |=> hrdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside read data phase");
    property p_unmap; take && !hwrite && haddr > CTRL_OFFSET |=> hrdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    // a wrap followed straight away by a status read must show the wrap flag
    property p_wrap; $past(ch4Counter) == CNT_MAX && ch4Counter == CNT_ZERO ##1 rdSts |=> hrdata[FLAG_WRAP];
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap flag missing after wrap");
endmodule // tsf_sva
bind tsf_status_flags tsf_sva tsf_sva_inst (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ch4Counter(ch4Counter), .irq(irq));
`default_nettype wire

//--- tsf_status_flags_tb.sv
// tsf_status_flags_tb: self-checking bench for the status flag block
// assumes the block is the only AHB-Lite slave, so hreadyout is hready
`default_nettype none
module tsf_status_flags_tb
    import tsf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic        hreadyout, hresp, pwm4, pwm5, irq;
    logic [1:0]  htrans = 2'h0;
    logic [7:0]  haddr = 8'h00;
    logic [31:0] hwdata = 32'h0, hrdata;
    logic [15:0] c4 = 16'h0000, c5 = 16'h0000, gr = 16'h5A5A;
    logic [3:0]  s4 = 4'h0;
    logic [2:0]  s5 = 3'h0;
    int          err_count = 0, samples_checked = 0;
    // one shared general value, so a single change makes every compare match at once
    tsf_status_flags tsf_status_flags_inst (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ch4Counter(c4), .ch4GeneralRegA(gr),
        .ch4GeneralRegB(gr), .ch4GeneralRegC(gr), .ch4GeneralRegD(gr), .ch4CaptureStrobe(s4),
        .ch5Counter(c5), .ch5GeneralRegA(gr), .ch5GeneralRegB(gr), .ch5GeneralRegC(gr),
        .ch5CaptureStrobe(s5), .ch4PwmMode(pwm4), .ch5PwmMode(pwm5), .irq(irq));
    // 250 MHz clock
    always #2 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    // single transfer, entered just after an edge; waits on hready, no fixed latency
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= a;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        cmp(r, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask
    // one cycle of every capture strobe together with general value g
    task automatic pulse(input logic [15:0] g);
        s4 <= 4'hF;
        s5 <= 3'h7;
        gr <= g;
        @(posedge clk);
        s4 <= 4'h0;
        s5 <= 3'h0;
        gr <= 16'h5A5A;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic testCapture();
        wr(CTRL_OFFSET, 32'h000007F0);
        pulse(16'h5A5A);
        wr(STATUS_OFFSET, 32'h0);
        rdChk(STATUS_OFFSET, 32'h00001DE0);
        wr(STATUS_OFFSET, 32'h00001FE0);
        rdChk(STATUS_OFFSET, 32'h00001DE0);
        wr(STATUS_OFFSET, 32'h0);
        rdChk(STATUS_OFFSET, 32'h0);
        $display("capture flags done");
    endtask
    task automatic testMatch(input logic [31:0] ctrl, input logic [31:0] e);
        wr(CTRL_OFFSET, ctrl);
        @(posedge clk);
        cmp({30'h0, pwm5, pwm4}, ctrl & 32'h3);
        pulse(16'h0000);
        rdChk(STATUS_OFFSET, e);
        wr(STATUS_OFFSET, 32'h0);
        $display("compare flags done");
    endtask
    task automatic testWrap();
        wr(MASK_OFFSET, 32'h00000200);
        c4 <= CNT_MAX;
        @(posedge clk);
        c4 <= CNT_ZERO;
        @(posedge clk);
        rdChk(STATUS_OFFSET, 32'h00000200);
        cmp({31'h0, irq}, 32'h1);
        wr(STATUS_OFFSET, 32'h0);
        @(posedge clk);
        cmp({31'h0, irq}, 32'h0);
        rdChk(STATUS_OFFSET, 32'h0);
        $display("wrap flag done");
    endtask
    // compare matches held every cycle, so the clearing write meets a fresh set
    task automatic testSetWins();
        wr(CTRL_OFFSET, 32'h0);
        gr <= 16'h0000;
        @(posedge clk);
        rdChk(STATUS_OFFSET, 32'h00001DE0);
        wr(STATUS_OFFSET, 32'h0);
        rdChk(STATUS_OFFSET, 32'h00001DE0);
        gr <= 16'h5A5A;
        wr(STATUS_OFFSET, 32'h0);
        rdChk(STATUS_OFFSET, 32'h0);
        $display("set over clear done");
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // watchdog, far beyond the fewer than a hundred cycles the tests need
    initial begin
        #40000;
        err_count++;
        complete_run();
    end
    // reset for 12 cycles, then the scenarios in turn
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdChk(STATUS_OFFSET, 32'h0);
        rdChk(8'h40, 32'h0);
        testCapture();
        testMatch(32'h0, 32'h00001DE0);
        testMatch(32'h3, 32'h00001100);
        testWrap();
        testSetWins();
        complete_run();
    end
endmodule // tsf_status_flags_tb
`default_nettype wire
